// ===== pkg/prmr_consts.svh
`ifndef PRMR_CONSTS_SVH
`define PRMR_CONSTS_SVH

// ****************************************************************
// Register word indices (byte address bits 4:2).
// ****************************************************************
`define PRMR_A_CDB_LO 3'h0
`define PRMR_A_CDB_HI 3'h1
`define PRMR_A_CTRL 3'h2
`define PRMR_A_DATA 3'h3
`define PRMR_A_STATUS 3'h4
`define PRMR_A_RESV 3'h5

// ****************************************************************
// Control bits.
// ****************************************************************
`define PRMR_C_GO 0
`define PRMR_C_BDR 1
`define PRMR_C_PRINTED 2
`define PRMR_C_BUFFERED 3
`define PRMR_C_TP_SUPP 8

// ****************************************************************
// Command fields and codes.
// ****************************************************************
`define PRMR_OP_PRINT 8'h0A
`define PRMR_OP_SLEW 8'h0B
`define PRMR_OP_MODE_SEL 8'h15
`define PRMR_OP_RESERVE 8'h16
`define PRMR_OP_RELEASE 8'h17
`define PRMR_HDR_MODE_BYTE 8'h02
`define PRMR_BMODE_HI 6
`define PRMR_BMODE_LO 4
`define PRMR_BMODE_BUFFERED 3'h1
`define PRMR_ST_GOOD 8'h00
`define PRMR_ST_CHECK 8'h02
`define PRMR_ST_CONFLICT 8'h18
`define PRMR_SK_NONE 4'h0
`define PRMR_SK_ILLEGAL 4'h5
`define PRMR_SK_UATTN 4'h6
`define PRMR_UA_RESET 8'hFF

`endif

// ===== pkg/prmr_pkg.sv
package prmr_pkg;

    // ************************************************************
    // Command engine states.
    // ************************************************************
    typedef enum logic [1:0] {
        PRMR_IDLE,
        PRMR_DATA,
        PRMR_PRINT_WAIT
    } prmr_state_e;

    typedef logic [2:0] prmr_id_t;

endpackage

// ===== rtl/prmr_core.sv
`timescale 1ns/1ps
`include "prmr_consts.svh"

module prmr_core (
    // Clock, reset and enable.
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    // Avalon-MM slave.
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o
);

    // ************************************************************
    // Bus slave.
    // ************************************************************
    logic wait_q;
    logic next_wait_q;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic acc;
    logic wr_acc;
    logic [2:0] widx;

    // Command registers and engine state.
    logic [31:0] cdb_lo;
    logic [31:0] next_cdb_lo;
    logic [15:0] cdb_hi;
    logic [15:0] next_cdb_hi;
    prmr_pkg::prmr_id_t init_id;
    prmr_pkg::prmr_id_t next_init_id;
    logic tp_supp;
    logic next_tp_supp;
    prmr_pkg::prmr_state_e state;
    prmr_pkg::prmr_state_e next_state;
    logic [7:0] remain;
    logic [7:0] next_remain;
    logic [7:0] bidx;
    logic [7:0] next_bidx;
    logic [2:0] bmode;
    logic [2:0] next_bmode;
    logic busy;
    logic next_busy;
    logic done;
    logic next_done;
    logic [7:0] stat;
    logic [7:0] next_stat;
    logic [3:0] sense;
    logic [3:0] next_sense;
    logic [7:0] ua;
    logic [7:0] next_ua;
    logic [7:0] rv;
    logic [7:0] next_rv;
    logic [7:0] rtp;
    logic [7:0] next_rtp;
    prmr_pkg::prmr_id_t holder [8];
    prmr_pkg::prmr_id_t next_holder [8];
    prmr_pkg::prmr_id_t rtpid [8];
    prmr_pkg::prmr_id_t next_rtpid [8];

    // Decoded command fields.
    logic [7:0] op;
    logic [2:0] lun;
    logic req_tp;
    prmr_pkg::prmr_id_t req_tpid;
    logic go;
    logic go_acc;
    logic data_wr;

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0] be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        merge = (old_v & ~m) | (new_v & m);
    endfunction

    // Owner for access checks: the named device of a third-party
    // reservation, otherwise the initiator that made it.
    function automatic prmr_pkg::prmr_id_t owner(input logic tp,
                                                 input prmr_pkg::prmr_id_t h,
                                                 input prmr_pkg::prmr_id_t d);
        owner = tp ? d : h;
    endfunction

    assign acc = (avs_read_i | avs_write_i) & ~wait_q;
    assign wr_acc = acc & avs_write_i;
    assign widx = avs_address_i[4:2];
    assign op = cdb_lo[7:0];
    assign lun = cdb_lo[15:13];
    assign req_tp = cdb_lo[12];
    assign req_tpid = cdb_lo[11:9];
    assign go = wr_acc && widx == `PRMR_A_CTRL && avs_byteenable_i[0]
        && avs_writedata_i[`PRMR_C_GO];
    assign go_acc = go && !busy;
    assign data_wr = wr_acc && widx == `PRMR_A_DATA && avs_byteenable_i[0];

    always_comb begin
        next_wait_q = 1'b1;
        next_rdata = rdata;
        if ((avs_read_i | avs_write_i) && wait_q) begin
            next_wait_q = 1'b0;
            next_rdata = 32'h0;
            if (avs_read_i) begin
                case (widx)
                    `PRMR_A_CDB_LO: next_rdata = cdb_lo;
                    `PRMR_A_CDB_HI: next_rdata = {13'h0, init_id, cdb_hi};
                    `PRMR_A_CTRL: next_rdata = {23'h0, tp_supp, 8'h0};
                    `PRMR_A_DATA: next_rdata = {24'h0, remain};
                    `PRMR_A_STATUS: next_rdata = {ua, 1'b0, bmode, sense,
                        stat, 6'h0, done, busy};
                    `PRMR_A_RESV: next_rdata = {24'h0, rtpid[lun], rtp[lun],
                        holder[lun], rv[lun]};
                    default: next_rdata = 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wait_q <= 1'b1;
            rdata <= 32'h0;
        end else if (ce_i) begin
            wait_q <= next_wait_q;
            rdata <= next_rdata;
        end
    end

    assign avs_readdata_o = rdata;
    assign avs_waitrequest_o = wait_q;

    // ************************************************************
    // Command engine.
    // ************************************************************
    always_comb begin
        next_cdb_lo = cdb_lo;
        next_cdb_hi = cdb_hi;
        next_init_id = init_id;
        next_tp_supp = tp_supp;
        next_state = state;
        next_remain = remain;
        next_bidx = bidx;
        next_bmode = bmode;
        next_busy = busy;
        next_done = done;
        next_stat = stat;
        next_sense = sense;
        next_ua = ua;
        next_rv = rv;
        next_rtp = rtp;
        next_holder = holder;
        next_rtpid = rtpid;
        if (wr_acc && widx == `PRMR_A_CDB_LO) begin
            next_cdb_lo = merge(cdb_lo, avs_writedata_i, avs_byteenable_i);
        end
        if (wr_acc && widx == `PRMR_A_CDB_HI) begin
            next_cdb_hi = 16'(merge({16'h0, cdb_hi}, avs_writedata_i,
                avs_byteenable_i));
            if (avs_byteenable_i[2]) begin
                next_init_id = avs_writedata_i[18:16];
            end
        end
        if (wr_acc && widx == `PRMR_A_CTRL && avs_byteenable_i[1]) begin
            next_tp_supp = avs_writedata_i[`PRMR_C_TP_SUPP];
        end
        if (go_acc) begin
            next_done = 1'b1;
            next_stat = `PRMR_ST_GOOD;
            next_sense = `PRMR_SK_NONE;
            if (ua[lun]) begin
                next_ua[lun] = 1'b0;
                next_stat = `PRMR_ST_CHECK;
                next_sense = `PRMR_SK_UATTN;
            end else if (op == `PRMR_OP_RESERVE) begin
                if (req_tp && !tp_supp) begin
                    next_stat = `PRMR_ST_CHECK;
                    next_sense = `PRMR_SK_ILLEGAL;
                end else if (rv[lun] && holder[lun] != init_id) begin
                    next_stat = `PRMR_ST_CONFLICT;
                end else begin
                    next_rv[lun] = 1'b1;
                    next_holder[lun] = init_id;
                    next_rtp[lun] = req_tp;
                    next_rtpid[lun] = req_tp ? req_tpid : 3'h0;
                end
            end else if (op == `PRMR_OP_RELEASE) begin
                if (req_tp && !tp_supp) begin
                    next_stat = `PRMR_ST_CHECK;
                    next_sense = `PRMR_SK_ILLEGAL;
                end else if (rv[lun] && holder[lun] == init_id
                    && rtp[lun] == req_tp
                    && (!req_tp || rtpid[lun] == req_tpid)) begin
                    next_rv[lun] = 1'b0;
                    next_rtp[lun] = 1'b0;
                    next_rtpid[lun] = 3'h0;
                    next_holder[lun] = 3'h0;
                end
            end else if (rv[lun]
                && owner(rtp[lun], holder[lun], rtpid[lun]) != init_id) begin
                next_stat = `PRMR_ST_CONFLICT;
            end else if (op == `PRMR_OP_MODE_SEL) begin
                if (cdb_hi[7:0] != 8'h0) begin
                    next_done = 1'b0;
                    next_busy = 1'b1;
                    next_state = prmr_pkg::PRMR_DATA;
                    next_remain = cdb_hi[7:0];
                    next_bidx = 8'h0;
                end
            end else if (op == `PRMR_OP_PRINT || op == `PRMR_OP_SLEW) begin
                next_done = 1'b0;
                next_busy = 1'b1;
                next_state = prmr_pkg::PRMR_PRINT_WAIT;
            end
        end else if (go) begin
            next_done = done;
        end
        case (state)
            prmr_pkg::PRMR_IDLE: begin
                next_state = next_state;
            end
            prmr_pkg::PRMR_DATA: begin
                if (data_wr) begin
                    if (bidx == `PRMR_HDR_MODE_BYTE) begin
                        next_bmode = avs_writedata_i[`PRMR_BMODE_HI:
                            `PRMR_BMODE_LO];
                    end
                    next_bidx = bidx + 8'h1;
                    next_remain = remain - 8'h1;
                    if (remain == 8'h1) begin
                        next_state = prmr_pkg::PRMR_IDLE;
                        next_busy = 1'b0;
                        next_done = 1'b1;
                    end
                end
            end
            prmr_pkg::PRMR_PRINT_WAIT: begin
                if (wr_acc && widx == `PRMR_A_CTRL && avs_byteenable_i[0]
                    && (avs_writedata_i[`PRMR_C_PRINTED]
                    || (bmode == `PRMR_BMODE_BUFFERED
                    && avs_writedata_i[`PRMR_C_BUFFERED]))) begin
                    next_state = prmr_pkg::PRMR_IDLE;
                    next_busy = 1'b0;
                    next_done = 1'b1;
                end
            end
            default: begin
                next_state = prmr_pkg::PRMR_IDLE;
                next_busy = 1'b0;
            end
        endcase
        if (wr_acc && widx == `PRMR_A_CTRL && avs_byteenable_i[0]
            && avs_writedata_i[`PRMR_C_BDR]) begin
            next_rv = 8'h0;
            next_rtp = 8'h0;
            next_ua = `PRMR_UA_RESET;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cdb_lo <= 32'h0;
            cdb_hi <= 16'h0;
            init_id <= 3'h0;
            tp_supp <= 1'b0;
            state <= prmr_pkg::PRMR_IDLE;
            remain <= 8'h0;
            bidx <= 8'h0;
            bmode <= 3'h0;
            busy <= 1'b0;
            done <= 1'b0;
            stat <= 8'h0;
            sense <= 4'h0;
            ua <= `PRMR_UA_RESET;
            rv <= 8'h0;
            rtp <= 8'h0;
            for (int i = 0; i < 8; i++) begin
                holder[i] <= 3'h0;
                rtpid[i] <= 3'h0;
            end
        end else if (ce_i) begin
            cdb_lo <= next_cdb_lo;
            cdb_hi <= next_cdb_hi;
            init_id <= next_init_id;
            tp_supp <= next_tp_supp;
            state <= next_state;
            remain <= next_remain;
            bidx <= next_bidx;
            bmode <= next_bmode;
            busy <= next_busy;
            done <= next_done;
            stat <= next_stat;
            sense <= next_sense;
            ua <= next_ua;
            rv <= next_rv;
            rtp <= next_rtp;
            holder <= next_holder;
            rtpid <= next_rtpid;
        end
    end

    // ************************************************************
    // Assertions.
    // ************************************************************
    logic plain_go;
    logic bdr_wr;
    assign plain_go = ce_i && go_acc && !ua[lun];
    assign bdr_wr = ce_i && wr_acc && widx == `PRMR_A_CTRL
        && avs_byteenable_i[0] && avs_writedata_i[`PRMR_C_BDR];

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    a_bus_answer: assert property (ce_i && (avs_read_i || avs_write_i)
        && wait_q |=> !avs_waitrequest_o) else $error("no bus answer");
    a_reserve_grant: assert property (plain_go && op == `PRMR_OP_RESERVE
        && !req_tp && !bdr_wr && (!rv[lun] || holder[lun] == init_id)
        |=> rv[$past(lun)] && holder[$past(lun)] == $past(init_id)
        && stat == `PRMR_ST_GOOD) else $error("reserve not granted");
    a_reserve_conflict: assert property (plain_go
        && op == `PRMR_OP_RESERVE && !(req_tp && !tp_supp) && rv[lun]
        && holder[lun] != init_id && !bdr_wr
        |=> stat == `PRMR_ST_CONFLICT
        && holder[$past(lun)] == $past(holder[lun]))
        else $error("conflict missed");
    a_tp_illegal: assert property (plain_go && req_tp && !tp_supp
        && (op == `PRMR_OP_RESERVE || op == `PRMR_OP_RELEASE)
        |=> stat == `PRMR_ST_CHECK && sense == `PRMR_SK_ILLEGAL)
        else $error("third party not refused");
    a_release_other: assert property (plain_go
        && op == `PRMR_OP_RELEASE && !req_tp && rv[lun]
        && holder[lun] != init_id && !bdr_wr
        |=> rv[$past(lun)] && stat == `PRMR_ST_GOOD)
        else $error("foreign release took effect");
    a_tp_release: assert property (plain_go
        && op == `PRMR_OP_RELEASE && req_tp && tp_supp && rv[lun]
        && !(rtp[lun] && holder[lun] == init_id && rtpid[lun] == req_tpid)
        && !bdr_wr |=> rv[$past(lun)] && stat == `PRMR_ST_GOOD)
        else $error("wrong third-party release took effect");
    a_unit_attn: assert property (ce_i && go_acc && ua[lun]
        |=> stat == `PRMR_ST_CHECK && sense == `PRMR_SK_UATTN
        && !ua[$past(lun)]) else $error("unit attention lost");
    a_bdr_clears: assert property (bdr_wr |=> rv == 8'h0
        && ua == `PRMR_UA_RESET) else $error("reset message ignored");
    a_zero_len: assert property (plain_go && op == `PRMR_OP_MODE_SEL
        && !rv[lun] && cdb_hi[7:0] == 8'h0
        |=> done && !busy && stat == `PRMR_ST_GOOD)
        else $error("zero length not good");
    a_print_hold: assert property (state == prmr_pkg::PRMR_PRINT_WAIT
        && bmode != `PRMR_BMODE_BUFFERED && !(wr_acc && widx == `PRMR_A_CTRL
        && avs_writedata_i[`PRMR_C_PRINTED]) |=> busy && !done)
        else $error("good before printed");
    a_mode_count: assert property (state == prmr_pkg::PRMR_DATA
        |-> remain != 8'h0 && busy) else $error("byte count broken");

    c_reserve: cover property (plain_go && op == `PRMR_OP_RESERVE);
    c_tp_release: cover property (plain_go && op == `PRMR_OP_RELEASE
        && req_tp && tp_supp);
    c_mode_done: cover property (state == prmr_pkg::PRMR_DATA
        ##1 state == prmr_pkg::PRMR_IDLE);
    c_print_buf: cover property (state == prmr_pkg::PRMR_PRINT_WAIT
        && bmode == `PRMR_BMODE_BUFFERED ##1 done);

endmodule

// ===== bench/prmr_init_model.sv
`timescale 1ns/1ps
`include "prmr_consts.svh"

module prmr_init_model (
    // Clock.
    input wire logic clk_i,
    // Avalon-MM master.
    output logic [4:0] avs_address_o,
    output logic avs_read_o,
    output logic avs_write_o,
    output logic [3:0] avs_byteenable_o,
    output logic [31:0] avs_writedata_o,
    input wire logic [31:0] avs_readdata_i,
    input wire logic avs_waitrequest_i,
    // Wait limit used up.
    output logic hung_o
);
    initial begin
        avs_address_o = 5'h00;
        avs_read_o = 1'b0;
        avs_write_o = 1'b0;
        avs_byteenable_o = 4'hF;
        avs_writedata_o = 32'h00000000;
        hung_o = 1'b0;
    end

    // Holds the request until waitrequest is sampled low, or for at most 64 cycles.
    task automatic xfer(input logic w, input logic [2:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        avs_address_o <= {a, 2'b00};
        avs_write_o <= w;
        avs_read_o <= ~w;
        avs_writedata_o <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (avs_waitrequest_i !== 1'b0 && n < 64);
        q = avs_readdata_i;
        if (n >= 64) hung_o <= 1'b1;
        avs_read_o <= 1'b0;
        avs_write_o <= 1'b0;
        avs_writedata_o <= ~d;
    endtask

    task automatic wr(input logic [2:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [2:0] a, output logic [31:0] q);
        xfer(1'b0, a, 32'h00000000, q);
    endtask

    // Loads a descriptor for logical unit zero.
    task automatic cdb(input logic [7:0] op, input logic tp,
                       input logic [2:0] id, input logic [7:0] len,
                       input logic [2:0] who);
        wr(`PRMR_A_CDB_LO, {16'h0000, 3'h0, tp, id, 1'b0, op});
        wr(`PRMR_A_CDB_HI, {13'h0000, who, 8'h00, len});
    endtask

    // Header first, then vendor bytes; only modes 0 and 1 are sent.
    function automatic logic [7:0] param_byte(input int i, input logic m);
        if (i == 2) return {3'h0, m, 4'h0};
        if (i < 4) return 8'h00;
        return 8'h70;
    endfunction
endmodule

// ===== bench/prmr_core_tb.sv
`timescale 1ns/1ps
`include "prmr_consts.svh"

module prmr_core_tb;
    logic clk_i;
    logic rstn_i;
    logic ce_i;
    logic [4:0] address;
    logic rd_en;
    logic wr_en;
    logic [3:0] be;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic wait_req;
    logic hung;
    logic tp_supp;
    logic [31:0] q;
    int mismatches;
    int total_checks;

    always #2.5 clk_i = ~clk_i;

    prmr_core uut (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i),
        .avs_address_i(address), .avs_read_i(rd_en), .avs_write_i(wr_en),
        .avs_byteenable_i(be), .avs_writedata_i(wdata),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req));

    prmr_init_model bus (.clk_i(clk_i), .avs_address_o(address),
        .avs_read_o(rd_en), .avs_write_o(wr_en), .avs_byteenable_o(be),
        .avs_writedata_o(wdata), .avs_readdata_i(rdata),
        .avs_waitrequest_i(wait_req), .hung_o(hung));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic go(input logic [7:0] op, input logic tp,
                      input logic [2:0] id, input logic [7:0] len,
                      input logic [2:0] who);
        bus.cdb(op, tp, id, len, who);
        bus.wr(`PRMR_A_CTRL, {23'h0, tp_supp, 8'h01});
    endtask

    task automatic st_is(input logic [7:0] st, input logic [3:0] sk,
                         input string what);
        logic [31:0] s;
        bus.rd(`PRMR_A_STATUS, s);
        chk({18'h0, s[19:8], s[1:0]}, {18'h0, sk, st, 2'b10}, what);
    endtask

    task automatic resv_is(input logic [7:0] exp, input string what);
        logic [31:0] s;
        bus.rd(`PRMR_A_RESV, s);
        chk({24'h0, s[7:0]}, {24'h0, exp}, what);
    endtask

    task automatic mode_sel(input logic m, input logic [7:0] len);
        go(`PRMR_OP_MODE_SEL, 1'b0, 3'h0, len, 3'h1);
        for (int i = 0; i < int'(len); i++) begin
            bus.rd(`PRMR_A_DATA, q);
            chk({24'h0, q[7:0]}, 32'(int'(len) - i), "bytes left");
            bus.wr(`PRMR_A_DATA, {24'h0, bus.param_byte(i, m)});
        end
        st_is(`PRMR_ST_GOOD, `PRMR_SK_NONE, "mode select end");
        bus.rd(`PRMR_A_STATUS, q);
        chk({29'h0, q[22:20]}, {31'h0, m}, "buffered mode");
    endtask

    task automatic t_reset;
        bus.rd(`PRMR_A_STATUS, q);
        chk(q, 32'hFF000000, "status after reset");
        resv_is(8'h00, "unit free after reset");
        go(8'h00, 1'b0, 3'h0, 8'h00, 3'h1);
        st_is(`PRMR_ST_CHECK, `PRMR_SK_UATTN, "attention");
        bus.rd(`PRMR_A_STATUS, q);
        chk({24'h0, q[31:24]}, 32'hFE, "attention cleared");
    endtask

    task automatic t_mode;
        go(`PRMR_OP_MODE_SEL, 1'b0, 3'h0, 8'h00, 3'h1);
        st_is(`PRMR_ST_GOOD, `PRMR_SK_NONE, "zero length");
        mode_sel(1'b1, 8'h06);
        mode_sel(1'b0, 8'h03);
    endtask

    task automatic t_print;
        go(`PRMR_OP_PRINT, 1'b0, 3'h0, 8'h00, 3'h1);
        bus.wr(`PRMR_A_CTRL, {23'h0, tp_supp, 8'h08});
        bus.rd(`PRMR_A_STATUS, q);
        chk({30'h0, q[1:0]}, 32'h1, "held until printed");
        ce_i <= 1'b0;
        fork
            bus.wr(`PRMR_A_CTRL, {23'h0, tp_supp, 8'h04});
            begin
                repeat (4) @(posedge clk_i);
                chk({31'h0, wait_req}, 32'h1, "frozen bus");
                ce_i <= 1'b1;
            end
        join
        st_is(`PRMR_ST_GOOD, `PRMR_SK_NONE, "printed");
        mode_sel(1'b1, 8'h04);
        go(`PRMR_OP_SLEW, 1'b0, 3'h0, 8'h00, 3'h1);
        bus.wr(`PRMR_A_CTRL, {23'h0, tp_supp, 8'h08});
        st_is(`PRMR_ST_GOOD, `PRMR_SK_NONE, "buffered good");
    endtask

    task automatic t_resv;
        go(`PRMR_OP_RESERVE, 1'b0, 3'h0, 8'h00, 3'h1);
        st_is(`PRMR_ST_GOOD, `PRMR_SK_NONE, "reserve");
        resv_is(8'h03, "held by one");
        go(`PRMR_OP_RESERVE, 1'b0, 3'h0, 8'h00, 3'h1);
        st_is(`PRMR_ST_GOOD, `PRMR_SK_NONE, "reserve again");
        go(`PRMR_OP_RESERVE, 1'b0, 3'h0, 8'h00, 3'h2);
        st_is(`PRMR_ST_CONFLICT, `PRMR_SK_NONE, "other reserve");
        go(`PRMR_OP_PRINT, 1'b0, 3'h0, 8'h00, 3'h2);
        st_is(`PRMR_ST_CONFLICT, `PRMR_SK_NONE, "other print");
        go(`PRMR_OP_RELEASE, 1'b0, 3'h0, 8'h00, 3'h2);
        st_is(`PRMR_ST_GOOD, `PRMR_SK_NONE, "other release");
        resv_is(8'h03, "still held");
        go(`PRMR_OP_RESERVE, 1'b1, 3'h3, 8'h00, 3'h1);
        st_is(`PRMR_ST_CHECK, `PRMR_SK_ILLEGAL, "tp reserve off");
        resv_is(8'h03, "kept on refusal");
        go(`PRMR_OP_RELEASE, 1'b1, 3'h3, 8'h00, 3'h1);
        st_is(`PRMR_ST_CHECK, `PRMR_SK_ILLEGAL, "tp release off");
        go(`PRMR_OP_RELEASE, 1'b0, 3'h0, 8'h00, 3'h1);
        st_is(`PRMR_ST_GOOD, `PRMR_SK_NONE, "release");
        resv_is(8'h00, "freed");
    endtask

    task automatic t_third;
        tp_supp = 1'b1;
        bus.wr(`PRMR_A_CTRL, {23'h0, tp_supp, 8'h00});
        bus.rd(`PRMR_A_CTRL, q);
        chk(q, 32'h00000100, "tp support");
        go(`PRMR_OP_RESERVE, 1'b1, 3'h5, 8'h00, 3'h1);
        st_is(`PRMR_ST_GOOD, `PRMR_SK_NONE, "tp reserve");
        resv_is(8'hB3, "held for five");
        go(`PRMR_OP_PRINT, 1'b0, 3'h0, 8'h00, 3'h1);
        st_is(`PRMR_ST_CONFLICT, `PRMR_SK_NONE, "maker locked out");
        go(`PRMR_OP_RELEASE, 1'b0, 3'h0, 8'h00, 3'h2);
        st_is(`PRMR_ST_GOOD, `PRMR_SK_NONE, "foreign release");
        resv_is(8'hB3, "not freed by other");
        go(`PRMR_OP_RELEASE, 1'b1, 3'h4, 8'h00, 3'h1);
        resv_is(8'hB3, "wrong id kept");
        go(`PRMR_OP_RESERVE, 1'b1, 3'h6, 8'h00, 3'h1);
        resv_is(8'hD3, "superseded");
        go(`PRMR_OP_RELEASE, 1'b1, 3'h6, 8'h00, 3'h1);
        st_is(`PRMR_ST_GOOD, `PRMR_SK_NONE, "tp release");
        bus.rd(`PRMR_A_RESV, q);
        chk({31'h0, q[0]}, 32'h0, "tp freed");
    endtask

    task automatic t_clear;
        go(`PRMR_OP_RESERVE, 1'b0, 3'h0, 8'h00, 3'h1);
        bus.wr(`PRMR_A_CTRL, {23'h0, tp_supp, 8'h02});
        bus.rd(`PRMR_A_RESV, q);
        chk({31'h0, q[0]}, 32'h0, "bus device reset clears");
        go(8'h00, 1'b0, 3'h0, 8'h00, 3'h2);
        st_is(`PRMR_ST_CHECK, `PRMR_SK_UATTN, "attention again");
        go(`PRMR_OP_RESERVE, 1'b0, 3'h0, 8'h00, 3'h1);
        @(posedge clk_i);
        rstn_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'b1;
        tp_supp = 1'b0;
        resv_is(8'h00, "hard reset clears");
        go(8'h00, 1'b0, 3'h0, 8'h00, 3'h1);
        st_is(`PRMR_ST_CHECK, `PRMR_SK_UATTN, "attention at reset");
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        if (hung === 1'b1) begin
            mismatches++;
            $display("[FAIL] %0t bus wait timed out", $time);
            tally_and_finish();
        end
    end

    initial begin
        clk_i = 1'b0;
        rstn_i = 1'b0;
        ce_i = 1'b1;
        tp_supp = 1'b0;
        mismatches = 0;
        total_checks = 0;
        repeat (10) @(posedge clk_i);
        rstn_i <= 1'b1;
        t_reset();
        t_mode();
        t_print();
        t_resv();
        t_third();
        t_clear();
        tally_and_finish();
    end
endmodule
